// File: rtl/rtcnv_slave.sv
// two-wire slave for nonvolatile array and clock/control register access
// assumes rd_data_i answers rd_addr_o/rd_ccr_o in the same cycle,
// and the open-drain wire is resolved from sda_oe_o outside
`timescale 1ns/1ns
`default_nettype none

module rtcnv_slave #(
  parameter int WR_CYCLES = rtcnv_pkg::NV_WRITE_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        wr_protect_i,
  input  wire logic [7:0]  rd_data_i,
  output logic      [15:0] rd_addr_o,
  output logic             rd_ccr_o,
  output logic             nv_wr_en_o,
  output logic             nv_wr_ccr_o,
  output logic      [15:0] nv_wr_addr_o,
  output logic      [7:0]  nv_wr_data_o,
  output logic             busy_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] page_mask(input logic clock_control_regs);
    page_mask = clock_control_regs ? rtcnv_pkg::CCR_MASK : rtcnv_pkg::ARRAY_MASK;
  endfunction

  function automatic logic [15:0] page_next(input logic [15:0] a, input logic clock_control_regs);
    logic [15:0] m;
    m         = page_mask(clock_control_regs);
    page_next = (a & ~m) | ((a + 16'h0001) & m);
  endfunction

  function automatic logic [15:0] space_next(input logic [15:0] a, input logic clock_control_regs);
    logic [15:0] last;
    last       = clock_control_regs ? rtcnv_pkg::CCR_LAST : rtcnv_pkg::ARRAY_LAST;
    space_next = (a >= last) ? rtcnv_pkg::ADDR_RESET : a + 16'h0001;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and bus conditions
  // ----------------------------------------------------------------
  logic       scl_s;
  logic       sda_s;
  logic       scl_d_r;
  logic       sda_d_r;

  rtcnv_sync #(
    .W (2)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .async_i   ({scl_i, sda_i}),
    .sync_o    ({scl_s, sda_s})
  );

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  wire scl_rise  = scl_s & ~scl_d_r;
  wire scl_fall  = ~scl_s & scl_d_r;
  wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rtcnv_pkg::rtcnv_state_t state_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  in_sr_r;
  logic [7:0]  out_sr_r;
  logic [7:0]  addr_hi_r;
  logic [15:0] addr_cnt_r;
  logic        tgt_ccr_r;
  logic        mack_r;
  logic [4:0]  data_cnt_r;
  logic        nv_start_r;
  logic [15:0] commit_base_r;
  logic        commit_ccr_r;
  logic [7:0]  page_buf_r [rtcnv_pkg::PAGE_MAX];
  logic [rtcnv_pkg::PAGE_MAX-1:0] valid_r;

  logic        nv_busy;
  logic        nv_step;
  logic [3:0]  nv_idx;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [3:0] id_w      = in_sr_r[7:rtcnv_pkg::ID_LSB];
  wire       sel_ok_w  = in_sr_r[3:rtcnv_pkg::SEL_LSB] == rtcnv_pkg::SEL_BITS;
  wire       id_arr_w  = id_w == rtcnv_pkg::ID_ARRAY;
  wire       id_ccr_w  = id_w == rtcnv_pkg::ID_CCR;
  wire       match_w   = sel_ok_w && (id_arr_w || id_ccr_w);  // [R1]
  wire       dir_rd_w  = in_sr_r[rtcnv_pkg::DIR_BIT];
  wire       recv_st_w = (state_r == rtcnv_pkg::ST_DEV) || (state_r == rtcnv_pkg::ST_AHI) ||
                         (state_r == rtcnv_pkg::ST_ALO) || (state_r == rtcnv_pkg::ST_WDATA);
  wire       fall8_w   = scl_fall && (bit_cnt_r == 4'h8);
  wire       fall9_w   = scl_fall && (bit_cnt_r == 4'h9);
  wire [15:0] base_w   = addr_cnt_r & ~page_mask(tgt_ccr_r);
  wire [15:0] mask_w   = page_mask(tgt_ccr_r);
  wire [3:0] buf_idx_w = addr_cnt_r[3:0] & mask_w[3:0];
  wire       buf_we_w  = !nv_busy && !start_det && !stop_det && fall8_w &&
                         (state_r == rtcnv_pkg::ST_WDATA);
  wire       buf_clr_w = !nv_busy && !start_det && !stop_det && fall8_w &&
                         (state_r == rtcnv_pkg::ST_ALO);
  // a stop lands just after the first rise of the next byte, so cnt 1 is clean
  wire       clean_w   = bit_cnt_r <= 4'h1;
  wire       alarm_w   = tgt_ccr_r && (base_w == rtcnv_pkg::ALARM_BASE) &&
                         (data_cnt_r == 5'h01);
  wire       commit_w  = stop_det && (state_r == rtcnv_pkg::ST_WDATA) && clean_w &&
                         (data_cnt_r != 5'h00) && !wr_protect_i && !alarm_w;

  // ----------------------------------------------------------------
  // transaction engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    nv_start_r <= 1'b0;
    if (reset_i) begin
      state_r    <= rtcnv_pkg::ST_IDLE;
      bit_cnt_r  <= 4'h0;
      in_sr_r    <= 8'h00;
      out_sr_r   <= 8'h00;
      addr_hi_r  <= 8'h00;
      addr_cnt_r <= rtcnv_pkg::ADDR_RESET;  // [R16]
      tgt_ccr_r  <= 1'b0;
      mack_r     <= 1'b0;
      data_cnt_r <= 5'h00;
      sda_oe_o   <= 1'b0;
    end else if (nv_busy) begin
      state_r  <= rtcnv_pkg::ST_IDLE;  // [R6] [R15] [R23]
      sda_oe_o <= 1'b0;
    end else if (start_det) begin
      state_r    <= rtcnv_pkg::ST_DEV;  // [R19]
      bit_cnt_r  <= 4'h0;
      data_cnt_r <= 5'h00;
      sda_oe_o   <= 1'b0;
    end else if (stop_det) begin
      // early stop just drops back; the buffer is never committed [R13] [R20]
      state_r    <= rtcnv_pkg::ST_IDLE;
      sda_oe_o   <= 1'b0;
      nv_start_r <= commit_w;  // [R6] [R7] [R8]
    end else begin
      if (scl_rise && bit_cnt_r < 4'h8) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
        if (recv_st_w) begin
          in_sr_r <= {in_sr_r[6:0], sda_s};
        end
      end
      if (scl_rise && bit_cnt_r == 4'h9 && state_r == rtcnv_pkg::ST_RDATA) begin
        mack_r <= ~sda_s;
      end
      if (scl_fall && state_r == rtcnv_pkg::ST_RDATA && bit_cnt_r != 4'h0 &&
          bit_cnt_r < 4'h8) begin
        out_sr_r <= {out_sr_r[6:0], 1'b0};
        sda_oe_o <= ~out_sr_r[6];
      end
      if (fall8_w) begin
        bit_cnt_r <= 4'h9;
        case (state_r)
          rtcnv_pkg::ST_DEV: begin
            if (match_w) begin
              sda_oe_o  <= 1'b1;  // [R1] [R17]
              tgt_ccr_r <= id_ccr_w;
            end else begin
              state_r <= rtcnv_pkg::ST_WAIT;  // [R2]
            end
          end
          rtcnv_pkg::ST_AHI: begin
            addr_hi_r <= in_sr_r;
            sda_oe_o  <= 1'b1;  // [R3] [R4]
          end
          rtcnv_pkg::ST_ALO: begin
            addr_cnt_r <= {addr_hi_r, in_sr_r};  // [R19] [R20]
            sda_oe_o   <= 1'b1;  // [R4]
          end
          rtcnv_pkg::ST_WDATA: begin
            addr_cnt_r <= page_next(addr_cnt_r, tgt_ccr_r);  // [R11] [R9]
            sda_oe_o   <= 1'b1;  // [R4] [R7]
            if (data_cnt_r != 5'h10) begin
              data_cnt_r <= data_cnt_r + 5'h01;
            end
          end
          rtcnv_pkg::ST_RDATA: begin
            sda_oe_o <= 1'b0;  // [R18]
          end
          default: begin
            sda_oe_o <= 1'b0;
          end
        endcase
      end
      if (fall9_w) begin
        bit_cnt_r <= 4'h0;
        sda_oe_o  <= 1'b0;
        case (state_r)
          rtcnv_pkg::ST_DEV: begin
            if (dir_rd_w) begin
              state_r    <= rtcnv_pkg::ST_RDATA;
              out_sr_r   <= rd_data_i;  // [R17]
              sda_oe_o   <= ~rd_data_i[7];
              addr_cnt_r <= space_next(addr_cnt_r, tgt_ccr_r);  // [R16] [R22]
            end else begin
              state_r <= rtcnv_pkg::ST_AHI;
            end
          end
          rtcnv_pkg::ST_AHI: begin
            state_r <= rtcnv_pkg::ST_ALO;
          end
          rtcnv_pkg::ST_ALO: begin
            state_r <= rtcnv_pkg::ST_WDATA;
          end
          rtcnv_pkg::ST_RDATA: begin
            if (mack_r) begin
              out_sr_r   <= rd_data_i;  // [R21]
              sda_oe_o   <= ~rd_data_i[7];
              addr_cnt_r <= space_next(addr_cnt_r, tgt_ccr_r);  // [R22]
            end else begin
              state_r <= rtcnv_pkg::ST_WAIT;  // [R18] [R21]
            end
          end
          default: begin
            state_r <= state_r;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // page buffer; later bytes overwrite earlier ones at wrapped slots
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      valid_r <= '0;
    end else if (buf_clr_w) begin
      valid_r <= '0;
    end else if (buf_we_w) begin
      valid_r[buf_idx_w]   <= 1'b1;  // [R12]
      page_buf_r[buf_idx_w] <= in_sr_r;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      commit_base_r <= 16'h0000;
      commit_ccr_r  <= 1'b0;
    end else if (commit_w && !nv_busy) begin
      commit_base_r <= base_w;
      commit_ccr_r  <= tgt_ccr_r;
    end
  end

  rtcnv_nvwr #(
    .WR_CYCLES (WR_CYCLES)
  ) u_nvwr (
    .clk_sys_i  (clk_sys_i),
    .reset_i    (reset_i),
    .start_i    (nv_start_r),
    .busy_o     (nv_busy),
    .step_o     (nv_step),
    .step_idx_o (nv_idx)
  );

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sda_o        <= 1'b0;
      rd_addr_o    <= rtcnv_pkg::ADDR_RESET;
      rd_ccr_o     <= 1'b0;
      nv_wr_en_o   <= 1'b0;
      nv_wr_ccr_o  <= 1'b0;
      nv_wr_addr_o <= 16'h0000;
      nv_wr_data_o <= 8'h00;
      busy_o       <= 1'b0;
    end else begin
      sda_o        <= 1'b0;
      rd_addr_o    <= addr_cnt_r;
      rd_ccr_o     <= tgt_ccr_r;
      nv_wr_en_o   <= nv_step && valid_r[nv_idx];  // [R6]
      nv_wr_ccr_o  <= commit_ccr_r;
      nv_wr_addr_o <= commit_base_r | {12'h000, nv_idx};
      nv_wr_data_o <= page_buf_r[nv_idx];
      busy_o       <= nv_busy;  // [R23]
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  a_busy_quiet: // [R6]
    assert property (nv_busy |-> !sda_oe_o)
    else $error("data line driven during write cycle");
  a_nack_bad_id: // [R2]
    assert property (!nv_busy && !start_det && !stop_det && fall8_w &&
                     state_r == rtcnv_pkg::ST_DEV && !match_w |=> !sda_oe_o)
    else $error("acknowledged a foreign address byte");
  a_ack_good_id: // [R1]
    assert property (!nv_busy && !start_det && !stop_det && fall8_w &&
                     state_r == rtcnv_pkg::ST_DEV && match_w |=> sda_oe_o)
    else $error("valid address byte not acknowledged");
  a_ack_data: // [R4]
    assert property (buf_we_w |=> sda_oe_o && state_r == rtcnv_pkg::ST_WDATA)
    else $error("data byte not acknowledged");
  a_early_stop: // [R13]
    assert property (stop_det && !nv_busy && data_cnt_r == 5'h00 |=> !nv_start_r)
    else $error("write cycle started without a data byte");
  a_protect_skip: // [R7]
    assert property (stop_det && wr_protect_i |=> !nv_start_r)
    else $error("protected write started a cycle");
  a_alarm_single: // [R8]
    assert property (stop_det && alarm_w |=> !nv_start_r)
    else $error("single byte started alarm register write");
  a_page_wrap: // [R11]
    assert property (buf_we_w && (addr_cnt_r & page_mask(tgt_ccr_r)) == page_mask(tgt_ccr_r)
                     |=> addr_cnt_r == $past(base_w))
    else $error("write address left its page");
  a_busy_follows: // [R14]
    assert property (nv_start_r && !nv_busy |=> ##1 nv_busy [*8])
    else $error("write cycle did not hold busy");
  a_cnt_start: // [R16]
    assert property ($fell(reset_i) |-> addr_cnt_r == rtcnv_pkg::ADDR_RESET)
    else $error("address counter not cleared");
  a_rd_advance: // [R21]
    assert property (!nv_busy && !start_det && !stop_det && fall9_w &&
                     state_r == rtcnv_pkg::ST_RDATA && mack_r
                     |=> addr_cnt_r == space_next($past(addr_cnt_r), tgt_ccr_r))
    else $error("read counter did not advance");

  c_read_ack:  cover property (fall9_w && state_r == rtcnv_pkg::ST_DEV && dir_rd_w);
  c_page_wrap: cover property (buf_we_w && buf_idx_w == 4'hf);
  c_nv_commit: cover property (nv_start_r);

endmodule
`default_nettype wire

// File: common/rtcnv_pkg.sv
// shared constants for the two-wire nonvolatile memory access slave
// assumes one 125 MHz system clock and an open-drain data pin resolved outside
//
// What this block does
// R1 - address byte: 1010 array, 1101 registers, 111
// R2 - no acknowledge for a non-matching address byte
// R3 - master sends two word address bytes
// R4 - acknowledge both address bytes and data byte
// R5 - master unlocks registers with 02h then 06h
// R6 - stop after write starts cycle; stay silent
// R7 - protected write acknowledged, no write cycle
// R8 - single byte never writes weekday alarm registers
// R9 - page of 16 array or 8 register bytes
// R10 - master writes clock registers as full page
// R11 - write address increments, wraps within page
// R12 - extra bytes overwrite earlier page bytes
// R13 - early stop aborts without writing anything
// R14 - write cycle about 5 ms, busy throughout
// R15 - poll with array address byte; ack when done
// R16 - address counter holds last read plus one
// R17 - read address byte acked, counter byte sent
// R18 - master ends read with no acknowledge, stop
// R19 - dummy write then repeated start reads there
// R20 - stop after word address sets the counter
// R21 - each master acknowledge sends the next byte
// R22 - read counter crosses pages, wraps at end
// R23 - busy flag gates address recognition
// R24 - write cycle length is a cycle count parameter

package rtcnv_pkg;

  // ----------------------------------------------------------------
  // address byte layout
  // ----------------------------------------------------------------
  localparam logic [3:0]  ID_ARRAY      = 4'ha;
  localparam logic [3:0]  ID_CCR        = 4'hd;
  localparam logic [2:0]  SEL_BITS      = 3'h7;
  localparam int          ID_LSB        = 4;
  localparam int          SEL_LSB       = 1;
  localparam int          DIR_BIT       = 0;

  // ----------------------------------------------------------------
  // address spaces and pages
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_RESET    = 16'h0000;
  localparam logic [15:0] ARRAY_LAST    = 16'h01ff;
  localparam logic [15:0] CCR_LAST      = 16'h003f;
  localparam logic [15:0] ARRAY_MASK    = 16'h000f;
  localparam logic [15:0] CCR_MASK      = 16'h0007;
  localparam logic [15:0] ALARM_BASE    = 16'h0008;
  localparam int          PAGE_MAX      = 16;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          NV_WRITE_NS   = 5000000;
  localparam int          NV_WRITE_CYC  = NV_WRITE_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_AHI,
    ST_ALO,
    ST_WDATA,
    ST_RDATA,
    ST_WAIT
  } rtcnv_state_t;

endpackage

// File: rtl/rtcnv_sync.sv
// two flip-flop synchroniser for the bus pins
// assumes inputs are asynchronous to clk_sys_i
`timescale 1ns/1ns
`default_nettype none

module rtcnv_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  // idle bus is high, so reset to ones to avoid a false start
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      meta_r <= '1;
      sync_o <= '1;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule
`default_nettype wire

// File: rtl/rtcnv_nvwr.sv
// nonvolatile write cycle timer and page commit stepper
// assumes start_i is a one-cycle pulse from the slave logic
`timescale 1ns/1ns
`default_nettype none

module rtcnv_nvwr #(
  parameter int WR_CYCLES = rtcnv_pkg::NV_WRITE_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       start_i,
  output logic            busy_o,
  output logic            step_o,
  output logic [3:0]      step_idx_o
);

  localparam int CW = $clog2(WR_CYCLES + 1);

  // a shorter cycle could not step through a whole page of slots
  if (WR_CYCLES < rtcnv_pkg::PAGE_MAX) begin : g_cfg_chk
    $error("WR_CYCLES must cover one page of commit steps");
  end

  logic [CW-1:0] cnt_r;
  wire           last_w = (cnt_r == CW'(WR_CYCLES - 1));
  wire           step_w = busy_o && (cnt_r < CW'(rtcnv_pkg::PAGE_MAX));

  // ----------------------------------------------------------------
  // busy window, set at start, cleared after the count
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      busy_o     <= 1'b0;
      cnt_r      <= '0;
      step_o     <= 1'b0;
      step_idx_o <= 4'h0;
    end else begin
      step_o     <= step_w;
      step_idx_o <= cnt_r[3:0];
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;  // [R23]
        cnt_r  <= '0;
      end else if (busy_o) begin
        cnt_r <= cnt_r + 1'b1;
        if (last_w) begin
          busy_o <= 1'b0;  // [R14] [R24]
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: dv/rtcnv_master.sv
// two-wire bus master model for the nonvolatile access slave
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ns
`default_nettype none

module rtcnv_master #(
  parameter int H = 6
) (
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  // ----------------------------------------------------------------
  // bus phases, each half period H clocks (slave needs >= 4)
  // ----------------------------------------------------------------
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // release first so a repeated start never looks like a stop
  task automatic start();
    sda_pull_o <= 1'b0;
    hold(H);
    scl_o <= 1'b1;
    hold(H);
    sda_pull_o <= 1'b1;
    hold(H);
    scl_o <= 1'b0;
    hold(H);
  endtask

  task automatic stop();
    sda_pull_o <= 1'b1;
    hold(H);
    scl_o <= 1'b1;
    hold(H);
    sda_pull_o <= 1'b0;
    hold(H);
  endtask

  // sample mid high phase on the falling clock edge, clear of the slave's update
  task automatic bit_io(input logic b, output logic r);
    sda_pull_o <= ~b;
    hold(H);
    scl_o <= 1'b1;
    hold(H / 2);
    @(negedge clk_sys_i);
    r = sda_i;
    hold(H / 2);
    scl_o <= 1'b0;
    hold(1);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule

`default_nettype wire

// File: dv/rtcnv_slave_bench.sv
// self-checking bench for the two-wire nonvolatile access slave
// assumes rtcnv_master as bus partner and a pattern memory on rd_data_i
`timescale 1ns/1ns
`default_nettype none

module rtcnv_slave_bench;
  // ----------------------------------------------------------------
  // signals and partners
  // ----------------------------------------------------------------
  localparam int WRC = 400;
  // status register slot inside the register space, assumed for the unlock writes
  localparam logic [15:0] STS_ADDR = 16'h003f;
  logic        clk_sys_i;
  logic        reset_i;
  logic        wr_protect_i;
  logic        scl;
  logic        pull;
  wire  logic  sda_w;
  logic        sda_o;
  logic        sda_oe_o;
  logic        rd_ccr_o;
  logic        nv_wr_en_o;
  logic        nv_wr_ccr_o;
  logic        busy_o;
  logic [15:0] rd_addr_o;
  logic [15:0] nv_wr_addr_o;
  logic [7:0]  rd_data_i;
  logic [7:0]  nv_wr_data_o;
  logic [7:0]  cdata [16];
  logic [15:0] caddr [16];
  logic        cccr;
  int          ccnt;
  int          n_errors;
  int          checks_done;

  // pattern keeps bits 11:8 visible so a wrong wrap target shows
  function automatic logic [7:0] img(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], 4'h0} ^ 8'ha5;
  endfunction

  assign sda_w = ~((sda_oe_o & ~sda_o) | pull);
  assign rd_data_i = img(rd_addr_o);

  rtcnv_slave #(.WR_CYCLES(WRC)) dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wr_protect_i(wr_protect_i),
    .rd_data_i(rd_data_i), .rd_addr_o(rd_addr_o), .rd_ccr_o(rd_ccr_o),
    .nv_wr_en_o(nv_wr_en_o), .nv_wr_ccr_o(nv_wr_ccr_o),
    .nv_wr_addr_o(nv_wr_addr_o), .nv_wr_data_o(nv_wr_data_o), .busy_o(busy_o)
  );

  rtcnv_master m (
    .clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(pull)
  );

  always #4 clk_sys_i = ~clk_sys_i;

  always @(posedge clk_sys_i) begin
    if (nv_wr_en_o === 1'b1) begin
      cdata[nv_wr_addr_o[3:0]] = nv_wr_data_o;
      caddr[nv_wr_addr_o[3:0]] = nv_wr_addr_o;
      cccr = nv_wr_ccr_o;
      ccnt = ccnt + 1;
    end
  end

  // ----------------------------------------------------------------
  // compare, verdict and transfer helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk1(input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wtx(input logic [7:0] sel, input logic [15:0] a, input int n,
                     input logic [7:0] d0);
    logic ack;
    ccnt = 0;
    m.start();
    m.wr_byte(sel, ack);
    chk1(1'b1, ack);
    m.wr_byte(a[15:8], ack);
    chk1(1'b1, ack);
    m.wr_byte(a[7:0], ack);
    chk1(1'b1, ack);
    for (int i = 0; i < n; i++) begin
      m.wr_byte(d0 + 8'(i), ack);
      chk1(1'b1, ack);
    end
    m.stop();
  endtask

  // no ack while busy, ack once done
  task automatic poll(output int nk);
    logic ack;
    nk = 0;
    ack = 1'b0;
    for (int i = 0; i < 40 && ack !== 1'b1; i++) begin
      m.start();
      m.wr_byte(8'hae, ack);
      m.stop();
      if (ack !== 1'b1) nk++;
    end
    chk1(1'b1, ack);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_addr();
    logic [7:0] b [5] = '{8'hae, 8'hde, 8'ha0, 8'h5e, 8'hac};
    logic ack;
    for (int i = 0; i < 5; i++) begin
      m.start();
      m.wr_byte(b[i], ack);
      chk1(b[i] == 8'hae || b[i] == 8'hde, ack);
      m.stop();
    end
  endtask

  task automatic s_page();
    int nk;
    logic [7:0] e;
    wtx(8'hae, 16'h001e, 18, 8'h40);
    m.hold(3);
    chk1(1'b1, busy_o);
    poll(nk);
    chk1(1'b1, nk > 0);
    chk1(1'b0, busy_o);
    chk(16'd16, 16'(ccnt));
    for (int s = 0; s < 16; s++) begin
      e = 8'h42 + 8'(s);
      chk({8'h00, e}, {8'h00, cdata[s]});
      chk(16'h0010 | 16'(s), caddr[s]);
    end
  endtask

  task automatic s_abort();
    logic ack;
    logic r;
    logic [7:0] d;
    ccnt = 0;
    m.start();
    m.wr_byte(8'hae, ack);
    m.wr_byte(8'h00, ack);
    m.wr_byte(8'h40, ack);
    for (int i = 0; i < 3; i++) m.bit_io(1'b1, r);
    m.stop();
    m.start();
    m.wr_byte(8'hae, ack);
    m.wr_byte(8'h00, ack);
    m.wr_byte(8'h35, ack);
    m.stop();
    m.hold(20);
    chk1(1'b0, busy_o);
    chk(16'h0000, 16'(ccnt));
    for (int k = 0; k < 2; k++) begin
      m.start();
      m.wr_byte(8'haf, ack);
      chk1(1'b1, ack);
      m.rd_byte(1'b0, d);
      m.stop();
      chk({8'h00, img(16'h0035 + 16'(k))}, {8'h00, d});
    end
  endtask

  task automatic s_prot();
    logic ack;
    @(posedge clk_sys_i);
    wr_protect_i <= 1'b1;
    wtx(8'hae, 16'h0050, 2, 8'h77);
    m.hold(20);
    chk1(1'b0, busy_o);
    chk(16'h0000, 16'(ccnt));
    wr_protect_i <= 1'b0;
    m.start();
    m.wr_byte(8'hae, ack);
    chk1(1'b1, ack);
    m.stop();
  endtask

  task automatic s_regs();
    int nk;
    wtx(8'hde, STS_ADDR, 1, 8'h02);
    poll(nk);
    wtx(8'hde, STS_ADDR, 1, 8'h06);
    poll(nk);
    wtx(8'hde, 16'h0008, 1, 8'h11);
    m.hold(20);
    chk1(1'b0, busy_o);
    chk(16'h0000, 16'(ccnt));
    wtx(8'hde, 16'h0000, 8, 8'h20);
    poll(nk);
    chk(16'd8, 16'(ccnt));
    chk1(1'b1, cccr);
  endtask

  task automatic s_seq(input logic [7:0] sel, input logic [15:0] a0, input logic [15:0] a1,
                       input logic [15:0] a2);
    logic ack;
    logic [7:0] d;
    logic [15:0] a [3];
    a = '{a0, a1, a2};
    m.start();
    m.wr_byte(sel, ack);
    m.wr_byte(a0[15:8], ack);
    m.wr_byte(a0[7:0], ack);
    m.start();
    m.wr_byte(sel | 8'h01, ack);
    chk1(1'b1, ack);
    chk1(sel[4], rd_ccr_o);
    for (int i = 0; i < 3; i++) begin
      m.rd_byte(i < 2, d);
      chk({8'h00, img(a[i])}, {8'h00, d});
    end
    m.stop();
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    reset_i = 1'b1;
    wr_protect_i = 1'b0;
    n_errors = 0;
    checks_done = 0;
    ccnt = 0;
    cccr = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    s_addr();
    s_page();
    s_abort();
    s_prot();
    s_regs();
    s_seq(8'hae, 16'h01fe, 16'h01ff, 16'h0000);
    s_seq(8'hde, 16'h003e, 16'h003f, 16'h0000);
    print_verdict();
  end

  // whole run is about 12k cycles
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    n_errors++;
    print_verdict();
  end
endmodule

`default_nettype wire
